// file: design/sar_seq_params.svh
// sequencing counts and field positions for the serial converter sequencer
`ifndef SAR_SEQ_PARAMS_SVH
`define SAR_SEQ_PARAMS_SVH

`define RES_BITS        12
`define BUF_DEPTH       2
`define CNT_W           5
`define CNT_START       5'd1
`define CNT_A2          5'd2
`define CNT_A1          5'd3
`define CNT_A0          5'd4
`define CNT_SAMPLE      5'd5
`define CNT_MODE        5'd6
`define CNT_PD1         5'd7
`define CNT_HOLD        5'd8
`define CNT_LAST_DECIDE 5'd20
`define CNT_FIRST_OUT   5'd10
`define CNT_LSB_OUT     5'd21
`define CNT_FRAME       5'd24
`define PD_RESET        2'h3

`endif

// file: design/sar_seq_pkg.sv
// types shared by the serial converter sequencer
package sar_seq_pkg;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_CTRL = 2'b01,
        ST_CONV = 2'b10,
        ST_PAD  = 2'b11
    } seq_phase_t;
endpackage : sar_seq_pkg

// file: design/sar_adc_serial_sequencer.sv
// serial control, multiplexer setup and conversion sequencing of the converter
// Function
// - single-ended channel index is chan_sel_bit_one*4+zero*2+two
// - differential pairs, chan_sel_bit_two swaps polarity
// - mux set only from serially shifted bits
// - first eight clocks carry the control byte
// - mux switched and acquisition entered early
// - three clocks later hold and convert
// - twelve clocks of successive approximation follow
// - thirteenth clock presents the final bit
// - three padding clocks ignored, output low
// - 12-bit unsigned result, step vref/4096
// - input sampled on rising serial_clock edge
// - output changes on falling edge, off when deselected
// - ignore input until high start bit
// - byte: start, sel bits, unused, mode, power_down_select
`timescale 1ns/1ps
`include "sar_seq_params.svh"

module sar_adc_serial_sequencer
    import sar_seq_pkg::*;
#(
    parameter int RES_BITS  = `RES_BITS,
    parameter int BUF_DEPTH = `BUF_DEPTH
)
(
    // clock and reset
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst,
    // serial link pins
    input  wire logic                 i_cs_n,
    input  wire logic                 i_serial_clock,
    input  wire logic                 i_din,
    output logic                      o_dout,
    output logic                      o_dout_oe,
    // analog front end control
    input  wire logic                 i_comparator,
    output logic [7:0]                o_mux_pos,
    output logic [7:0]                o_mux_neg,
    output logic                      o_mux_neg_com,
    output logic                      o_sampling,
    output logic                      o_hold,
    output logic [RES_BITS-1:0]       o_dac_trial,
    output logic [1:0]                o_power_down_select,
    // result stream
    input  wire logic                 i_result_ready,
    output logic [RES_BITS-1:0]       o_result_data,
    output logic                      o_result_valid
);
    localparam int BW = RES_BITS;
    localparam int CW = $clog2(BUF_DEPTH + 1);

    typedef struct packed {
        logic [2:0]                  sclk_sync;
        logic [1:0]                  cs_sync;
        logic [1:0]                  din_sync;
        seq_phase_t                  phase;
        logic [`CNT_W-1:0]           cnt;
        logic                        a2;
        logic                        a1;
        logic                        a0;
        logic                        mode;
        logic [1:0]                  pd;
        logic [BW-1:0]               trial;
        logic [7:0]                  mux_pos;
        logic [7:0]                  mux_neg;
        logic                        mux_com;
        logic                        sampling;
        logic                        hold;
        logic                        dout;
        logic                        dout_oe;
        logic [BUF_DEPTH-1:0][BW-1:0] buf_data;
        logic [CW-1:0]               buf_cnt;
        logic                        buf_valid;
    } seq_state_t;

    seq_state_t st;
    seq_state_t next_st;

    // channel index shared by both input modes
    function automatic logic [2:0] chan_index(input logic a2, input logic a1, input logic a0);
        chan_index = {a1, a0, a2};
    endfunction : chan_index

    logic                 rise;
    logic                 fall;
    logic                 cs_active;
    logic                 buf_full;
    logic [`CNT_W-1:0]    next_cnt;
    logic [3:0]           bit_idx;
    logic                 push;
    logic                 pop;
    logic [BW-1:0]        push_data;

    // edge finding works on the settled copies only
    assign rise      = st.sclk_sync[1] & ~st.sclk_sync[2];
    assign fall      = ~st.sclk_sync[1] & st.sclk_sync[2];
    assign cs_active = ~st.cs_sync[1];
    assign buf_full  = (st.buf_cnt == CW'(BUF_DEPTH));
    assign next_cnt  = st.cnt + `CNT_W'(1);
    assign bit_idx   = 4'(`CNT_LAST_DECIDE - next_cnt);

    always_comb
    begin
        next_st   = st;
        push      = 1'b0;
        push_data = st.trial;
        pop       = st.buf_valid & i_result_ready;
        // two flip-flop synchronisers, third stage for edges
        next_st.sclk_sync = {st.sclk_sync[1:0], i_serial_clock};
        next_st.cs_sync   = {st.cs_sync[0], i_cs_n};
        next_st.din_sync  = {st.din_sync[0], i_din};
        next_st.dout_oe   = cs_active;

        if (!cs_active)
        begin
            // deselect aborts any frame in flight
            next_st.phase    = ST_IDLE;
            next_st.cnt      = '0;
            next_st.sampling = 1'b0;
            next_st.hold     = 1'b0;
            next_st.dout     = 1'b0;
        end
        else if (rise)
        begin
            unique case (st.phase)
                ST_IDLE:
                begin
                    // full buffer refuses a new frame so no word is lost
                    if (st.din_sync[1] && !buf_full)
                    begin
                        next_st.phase = ST_CTRL;
                        next_st.cnt   = `CNT_START;
                    end
                end
                ST_CTRL:
                begin
                    next_st.cnt = next_cnt;
                    // field capture by bit position, msb first
                    if (next_cnt == `CNT_A2) next_st.a2 = st.din_sync[1];
                    if (next_cnt == `CNT_A1) next_st.a1 = st.din_sync[1];
                    if (next_cnt == `CNT_A0) next_st.a0 = st.din_sync[1];
                    if (next_cnt == `CNT_MODE) next_st.mode = st.din_sync[1];
                    if (next_cnt == `CNT_PD1) next_st.pd[1] = st.din_sync[1];
                    if (next_cnt == `CNT_HOLD) next_st.pd[0] = st.din_sync[1];
                    if (next_cnt >= `CNT_A0)
                    begin
                        // mux follows shifted bits only, mode settles two clocks later
                        next_st.mux_pos = 8'h01 << chan_index(next_st.a2, next_st.a1,
                                                              next_st.a0);
                        next_st.mux_neg = next_st.mode ? 8'h00 :
                            8'h01 << chan_index(~next_st.a2, next_st.a1, next_st.a0);
                        next_st.mux_com = next_st.mode;
                    end
                    if (next_cnt == `CNT_SAMPLE)
                        next_st.sampling = 1'b1;
                    if (next_cnt == `CNT_HOLD)
                    begin
                        next_st.sampling = 1'b0;
                        next_st.hold     = 1'b1;
                        next_st.phase    = ST_CONV;
                        next_st.trial    = BW'(1) << (BW - 1);
                    end
                end
                ST_CONV:
                begin
                    // one decision per clock, msb down to lsb
                    next_st.cnt = next_cnt;
                    if (!i_comparator)
                        next_st.trial[bit_idx] = 1'b0;
                    if (bit_idx != 4'h0)
                        next_st.trial[bit_idx - 4'h1] = 1'b1;
                    if (next_cnt == `CNT_LAST_DECIDE)
                    begin
                        next_st.hold  = 1'b0;
                        next_st.phase = ST_PAD;
                        push          = 1'b1;
                        push_data     = next_st.trial;
                    end
                end
                ST_PAD:
                begin
                    // trailing clocks only counted
                    next_st.cnt = next_cnt;
                    if (next_cnt == `CNT_FRAME)
                        next_st.phase = ST_IDLE;
                end
            endcase
        end
        else if (fall)
        begin
            // output changes only on the falling edge
            if (st.cnt >= `CNT_FIRST_OUT && st.cnt <= `CNT_LSB_OUT && st.phase != ST_CTRL)
                next_st.dout = st.trial[4'(`CNT_LSB_OUT - st.cnt)];
            else
                next_st.dout = 1'b0;
        end

        // result buffer: shift out at head, append at tail
        if (pop)
        begin
            for (int i = 0; i < BUF_DEPTH - 1; i++)
                next_st.buf_data[i] = st.buf_data[i + 1];
        end
        if (push)
            next_st.buf_data[CW'(st.buf_cnt - CW'(pop))] = push_data;
        next_st.buf_cnt   = st.buf_cnt + CW'(push) - CW'(pop);
        next_st.buf_valid = (next_st.buf_cnt != '0);
    end

    // single register of all state
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            st           <= '0;
            st.sclk_sync <= 3'h0;
            st.cs_sync   <= 2'h3;
            st.phase     <= ST_IDLE;
            st.pd        <= `PD_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end
    assign o_dout              = st.dout;
    assign o_dout_oe           = st.dout_oe;
    assign o_mux_pos           = st.mux_pos;
    assign o_mux_neg           = st.mux_neg;
    assign o_mux_neg_com       = st.mux_com;
    assign o_sampling          = st.sampling;
    assign o_hold              = st.hold;
    assign o_dac_trial         = st.trial;
    assign o_power_down_select = st.pd;
    assign o_result_data       = st.buf_data[0];
    assign o_result_valid      = st.buf_valid;
    // checks on the sequencing; counts are the values held before the edge
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    property p_oe_off_deselected;
        st.cs_sync[1] |=> !o_dout_oe ##0 !o_dout;
    endproperty
    a_oe_off_deselected: assert property (p_oe_off_deselected)
        else $error("output enabled while deselected");
    property p_wait_start;
        (st.phase == ST_IDLE) && rise && !st.din_sync[1] |=> st.phase == ST_IDLE;
    endproperty
    a_wait_start: assert property (p_wait_start)
        else $error("frame started without start bit");
    property p_sample_fifth;
        cs_active && rise && st.phase == ST_CTRL && st.cnt == `CNT_A0 |=> o_sampling && !o_hold;
    endproperty
    a_sample_fifth: assert property (p_sample_fifth)
        else $error("acquisition not entered on fifth clock");
    property p_hold_eighth;
        cs_active && rise && st.phase == ST_CTRL && st.cnt == `CNT_PD1
            |=> o_hold && !o_sampling && st.phase == ST_CONV;
    endproperty
    a_hold_eighth: assert property (p_hold_eighth)
        else $error("hold not entered on eighth clock");
    property p_mux_stable;
        !(rise && st.phase == ST_CTRL) |=> $stable(o_mux_pos) && $stable(o_mux_neg);
    endproperty
    a_mux_stable: assert property (p_mux_stable)
        else $error("mux changed outside control byte");
    property p_diff_pair;
        o_hold && !o_mux_neg_com |-> (o_mux_pos == (o_mux_neg << 1)) ||
                                     (o_mux_neg == (o_mux_pos << 1));
    endproperty
    a_diff_pair: assert property (p_diff_pair)
        else $error("differential pair not adjacent");
    property p_twelve_decisions;
        cs_active && rise && st.phase == ST_CONV && st.cnt == `CNT_LAST_DECIDE - `CNT_START
            |=> st.phase == ST_PAD && !o_hold && st.buf_cnt == $past(st.buf_cnt) + CW'(1)
                - CW'($past(pop));
    endproperty
    a_twelve_decisions: assert property (p_twelve_decisions)
        else $error("conversion did not end after twelve clocks");
    property p_lsb_thirteenth;
        cs_active && fall && st.phase == ST_PAD && st.cnt == `CNT_LSB_OUT
            |=> o_dout == st.trial[0];
    endproperty
    a_lsb_thirteenth: assert property (p_lsb_thirteenth)
        else $error("lsb not presented on thirteenth clock");
    property p_pad_low;
        fall && st.phase == ST_PAD && st.cnt > `CNT_LSB_OUT |=> !o_dout;
    endproperty
    a_pad_low: assert property (p_pad_low)
        else $error("output not low during padding");
    c_full_frame: cover property (rise && st.phase == ST_PAD && st.cnt == 5'd23);
    c_diff_mode:  cover property (o_hold && !o_mux_neg_com);
    c_buf_full:   cover property (buf_full && cs_active && rise && st.din_sync[1]);
endmodule : sar_adc_serial_sequencer

// file: tb/serial_master.sv
// serial master model: frames control bytes and collects result bits on the link
`timescale 1ns/1ps

module serial_master
(
    // link pins
    output logic o_cs_n,
    output logic o_serial_clock,
    output logic o_din,
    input  wire  i_dout,
    // current clock number within the frame, 1 = start bit
    output int   o_edge_no
);
    initial
    begin
        o_cs_n         = 1'b1;
        o_serial_clock = 1'b0; // clock stands still outside frames
        o_din          = 1'b1;
        o_edge_no      = 0;
    end

    // one frame: lead zeros, control byte, then clocks up to stop (24 when whole)
    task automatic frame(input logic [7:0] ctrl, input int lead, input int stop,
                         output logic [23:0] word);
        word      = 24'h0;
        o_edge_no = 0;
        #13;
        o_cs_n = 1'b0;
        #200;
        for (int k = 1 - lead; k <= stop; k++) // lead clocks, then clocks 1 to stop
        begin
            // data only changes at the falling edge
            o_din = (k >= 1 && k <= 8) ? ctrl[8 - k] : 1'b0;
            #160;
            o_serial_clock = 1'b1;
            o_edge_no      = k;
            #159;
            if (k >= 1)
                word = {word[22:0], i_dout};
            #1;
            o_serial_clock = 1'b0;
        end
        #160;
        o_cs_n = 1'b1;
        o_din  = ~o_din; // released line must not keep its last level
    endtask : frame
endmodule : serial_master

// file: tb/tb.sv
// self-checking bench for the serial converter sequencer against a master model
`timescale 1ns/1ps
`include "sar_seq_params.svh"

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb;
    // clock, reset and stimulus
    logic                 ref_clk    = 1'b0;
    logic                 rst        = 1'b1;
    logic                 ready      = 1'b0;
    logic                 ready_mode = 1'b0;
    logic [`RES_BITS-1:0] vin        = '0;
    wire                  comparator;
    wire                  cs_n, sclk, din, dout, dout_oe, link_dout;
    wire                  neg_com, sampling, hold, valid;
    wire  [7:0]           mux_pos, mux_neg;
    wire  [`RES_BITS-1:0] trial, rdata;
    wire  [1:0]           pd_sel;
    int                   edge_no;
    int                   n_errors   = 0;
    int                   tests_run  = 0;
    int                   seed       = 49;
    logic [`RES_BITS-1:0] exp_q[$];
    logic [`RES_BITS-1:0] got_q[$];

    always #20 ref_clk = ~ref_clk;
    // ideal front end: keep the trial bit while it does not exceed the sample
    assign comparator = (trial <= vin);
    assign link_dout  = dout_oe ? dout : 1'bz; // undriven wire floats at z

    // random stalls by the result sink; words taken are logged
    always @(posedge ref_clk)
    begin
        if (valid === 1'b1 && ready === 1'b1)
            got_q.push_back(rdata);
        #1;
        ready = ready_mode && (($random(seed) & 1) != 0);
    end

    sar_adc_serial_sequencer sar_adc_serial_sequencer_i (
        .i_ref_clk(ref_clk), .i_rst(rst), .i_cs_n(cs_n), .i_serial_clock(sclk),
        .i_din(din), .o_dout(dout), .o_dout_oe(dout_oe), .i_comparator(comparator),
        .o_mux_pos(mux_pos), .o_mux_neg(mux_neg), .o_mux_neg_com(neg_com),
        .o_sampling(sampling), .o_hold(hold), .o_dac_trial(trial),
        .o_power_down_select(pd_sel), .i_result_ready(ready),
        .o_result_data(rdata), .o_result_valid(valid));

    serial_master serial_master_i (
        .o_cs_n(cs_n), .o_serial_clock(sclk), .o_din(din), .i_dout(link_dout),
        .o_edge_no(edge_no));

    task automatic results();
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    // bounded wait for a given serial clock, then let the design catch up
    task automatic wait_edge(input int n);
        int t;
        t = 0;
        while (edge_no != n && t < 4000)
        begin
            @(posedge ref_clk);
            t++;
        end
        if (t >= 4000)
        begin
            n_errors++;
            results();
        end
        #240;
    endtask : wait_edge

    task automatic do_reset(input int n);
        @(posedge ref_clk);
        #1;
        rst = 1'b1;
        repeat (n) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        `CHK({pd_sel, valid, dout_oe, hold}, 5'h18)
        repeat (4) @(posedge ref_clk);
    endtask : do_reset

    // one whole conversion; push low means the start bit must be refused
    task automatic run_frame(input logic [7:0] ctrl, input int lead, input logic push);
        logic [23:0] word;
        logic [7:0]  pos;
        logic [7:0]  neg;
        pos = 8'h01 << {ctrl[5], ctrl[4], ctrl[6]};
        neg = ctrl[2] ? 8'h00 : 8'h01 << {ctrl[5], ctrl[4], ~ctrl[6]};
        @(posedge ref_clk);
        #1;
        vin = `RES_BITS'($random(seed));
        fork
            serial_master_i.frame(ctrl, lead, 24, word);
            begin
                wait_edge(6);
                `CHK({sampling, hold, dout_oe}, {push, 2'b01})
                wait_edge(12);
                if (push)
                begin
                    `CHK({sampling, hold, neg_com}, {2'b01, ctrl[2]})
                    `CHK({mux_pos, mux_neg}, {pos, neg})
                    `CHK(pd_sel, ctrl[1:0])
                end
            end
        join
        `CHK(word[14:0], push ? {1'b0, vin, 2'b00} : 15'h0)
        if (push)
            exp_q.push_back(vin);
    endtask : run_frame

    // let the sink take everything and compare in order
    task automatic drain();
        int                   t;
        logic [`RES_BITS-1:0] g;
        logic [`RES_BITS-1:0] e;
        int                   sum_g;
        int                   sum_e;
        ready_mode = 1'b1;
        t = 0;
        sum_g = 0;
        sum_e = 0;
        while (got_q.size() < exp_q.size() && t < 400)
        begin
            @(posedge ref_clk);
            t++;
        end
        repeat (8) @(posedge ref_clk);
        `CHK(got_q.size(), exp_q.size())
        while (exp_q.size() > 0 && got_q.size() > 0)
        begin
            g = got_q.pop_front();
            e = exp_q.pop_front();
            `CHK(g, e)
            sum_g += g;
            sum_e += e;
        end
        // a receiver that averages consecutive words must see the same mean
        `CHK(sum_g, sum_e)
        exp_q.delete();
        got_q.delete();
    endtask : drain

    // all channels in both modes, then a full buffer, an abort and a reset
    initial
    begin
        logic [31:0] r;
        logic [23:0] word;
        do_reset(12);
        ready_mode = 1'b1;
        for (int c = 0; c < 16; c++)
        begin
            r = $random(seed);
            run_frame({1'b1, c[2:0], r[0], c[3], r[2:1]}, int'(r[5:4]), 1'b1);
        end
        drain();
        ready_mode = 1'b0;
        repeat (2) run_frame(8'he4, 0, 1'b1);
        run_frame(8'hd3, 0, 1'b0); // buffer full refuses the start
        drain();
        serial_master_i.frame(8'h94, 0, 12, word);
        repeat (8) @(posedge ref_clk);
        `CHK({dout_oe, dout}, 2'b00)
        drain();
        do_reset(2);
        run_frame(8'hb0, 1, 1'b1);
        drain();
        results();
    end
endmodule : tb
